// *** src/svc_chan_pkg.sv ***
// package: constants and types for the service async channel framer
// assumes one 40 MHz clock and synchronous active-high reset
package svc_chan_pkg;

  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int unsigned CLK_HZ       = 40000000;
  localparam int unsigned CLK_PERIOD_NS = 25;

  // ------------------------------------------------------------
  // overhead sizing
  // ------------------------------------------------------------
  localparam int unsigned N_MIN        = 1;
  localparam int unsigned N_MAX        = 256;
  localparam int unsigned N_W          = 9;
  localparam logic [8:0]  N_RESET      = 9'h100;

  // ------------------------------------------------------------
  // character format on the overhead
  // ------------------------------------------------------------
  localparam int unsigned CHAR_BITS    = 8;
  localparam int unsigned SLOT_BITS    = 9;   // marker plus character
  localparam logic        MARKER_BIT   = 1'b0;
  localparam logic        IDLE_BIT     = 1'b1;
  localparam logic [3:0]  BIT_CNT_LAST = 4'h8;

  // ------------------------------------------------------------
  // uart
  // ------------------------------------------------------------
  localparam int unsigned DIV_W        = 16;
  localparam logic [15:0] DIV_RESET    = 16'h1046; // 40 MHz / 9600 baud
  localparam logic [3:0]  OVS_LAST     = 4'hf;

  // ------------------------------------------------------------
  // buffers
  // ------------------------------------------------------------
  localparam int unsigned FIFO_DEPTH   = 4;
  localparam int unsigned FIFO_AW      = 2;

  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b11,
    TX_STOP  = 2'b10
  } uart_tx_state_t;

endpackage : svc_chan_pkg

// *** src/svc_byte_fifo.sv ***
// small synchronous byte fifo with valid/ready on both sides
// assumes one clock; flush empties it in one cycle
`timescale 1ns/1ps
module svc_byte_fifo #(
  parameter int unsigned DEPTH = 4,
  parameter int unsigned AW    = 2
) (
  input  wire logic       clk,      // clock
  input  wire logic       rst,      // sync reset
  input  wire logic       flush,    // drop all content
  input  wire logic [7:0] in_data,  // write data
  input  wire logic       in_valid, // write request
  output logic            in_ready, // not full
  output logic [7:0]      out_data, // head data
  output logic            out_valid,// not empty
  input  wire logic       out_ready // read accept
);
  logic [7:0]  mem [DEPTH];
  logic [AW:0] wr_ptr;
  logic [AW:0] rd_ptr;
  logic [AW:0] next_wr_ptr;
  logic [AW:0] next_rd_ptr;
  logic        push;
  logic        pop;

  assign in_ready  = (wr_ptr - rd_ptr) != (AW+1)'(DEPTH);
  assign out_valid = wr_ptr != rd_ptr;
  assign out_data  = mem[rd_ptr[AW-1:0]];
  assign push      = in_valid && in_ready;
  assign pop       = out_valid && out_ready;

  always_comb begin
    next_wr_ptr = wr_ptr;
    next_rd_ptr = rd_ptr;
    if (flush) begin
      next_wr_ptr = '0;
      next_rd_ptr = '0;
    end else begin
      if (push) next_wr_ptr = wr_ptr + 1'b1;
      if (pop)  next_rd_ptr = rd_ptr + 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      wr_ptr <= '0;
      rd_ptr <= '0;
    end else begin
      wr_ptr <= next_wr_ptr;
      rd_ptr <= next_rd_ptr;
    end
  end

  always_ff @(posedge clk) begin
    if (push && !flush) mem[wr_ptr[AW-1:0]] <= in_data;
  end

endmodule : svc_byte_fifo

// *** src/svc_async_mux.sv ***
// service async channel carried in frame overhead bits
// assumes the framer presents one overhead slot strobe per assigned bit
`timescale 1ns/1ps
// Contract
// - overhead is sized as 1/N, N 1..256, the smallest fraction giving at least the baud rate; the code picks it only in MIN_OH mode, else N is 1.
// - minimum-overhead mode adds the smallest fraction that still carries the channel.
// - each received local uart character becomes a byte held in a fifo before insertion; the code drops characters that arrive while the 4-deep fifo is full.
// - a character goes out as one 0 marker then 8 bits; an idle channel sends no marker.
// - the 8 bits may be one per frame or consecutive overhead slots.
// - every locally assigned overhead bit goes to the decoder regardless of far-end use; the code drops a bit whose slot falls in an overrun cycle.
// - a receive fifo sits between extraction and the uart, drained at the uart baud rate.
// - an overrun must not leave characters held back in the pipe.
// - the delayed-character state is never entered, so reconfiguration needs no reset.
// - both ends share rate, baud, format, alarm and baseband settings.
// - with all remaining overhead given to the channel, it takes maximum capacity.
module svc_async_mux (
  input  wire logic             MCLK,        // 40 MHz clock
  input  wire logic             RESET,       // sync reset, active high
  input  wire logic [svc_chan_pkg::DIV_W-1:0] BAUD_DIV, // clocks per 1/16 baud, minus one
  input  wire logic [31:0]      OH_BITS_RATE,// overhead bits per second at N=1
  input  wire logic [31:0]      REQ_BITS_RATE,// needed channel bits per second
  input  wire logic             MIN_OH,      // minimum-overhead mode
  input  wire logic             ALL_REMAIN,  // channel takes all remaining overhead
  output logic      [svc_chan_pkg::N_W-1:0] OH_DIVISOR, // chosen N
  input  wire logic             UART_RXD,    // local uart input
  output logic                  UART_TXD,    // local uart output
  input  wire logic             TX_SLOT,     // pulse: an assigned tx overhead bit
  output logic                  TX_BIT,      // bit for that slot
  input  wire logic             RX_SLOT,     // pulse: an assigned rx overhead bit
  input  wire logic             RX_BIT,      // received overhead bit
  input  wire logic             OVR_CLR,     // clear overrun flag
  output logic                  OVR_FLAG     // sticky overrun
);
  import svc_chan_pkg::*;

  // ------------------------------------------------------------
  // overhead divisor choice
  // ------------------------------------------------------------
  logic [N_W-1:0] n_sel;
  logic [N_W-1:0] next_n_sel;
  always_comb begin
    next_n_sel = 9'h001;
    if (ALL_REMAIN) begin
      next_n_sel = 9'h001;
    end else if (MIN_OH) begin
      // largest N whose share still meets the request
      for (int i = N_MIN; i <= N_MAX; i++) begin
        if (64'(OH_BITS_RATE) >= 64'(REQ_BITS_RATE) * 64'(i))
          next_n_sel = N_W'(i);
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (RESET) n_sel <= N_RESET;
    else       n_sel <= next_n_sel;
  end
  assign OH_DIVISOR = n_sel;

  // ------------------------------------------------------------
  // baud tick, 16x oversample
  // ------------------------------------------------------------
  logic [DIV_W-1:0] div_cnt;
  logic [DIV_W-1:0] next_div_cnt;
  logic             tick;
  assign tick = (div_cnt == '0);
  always_comb next_div_cnt = tick ? BAUD_DIV : div_cnt - 1'b1;
  always_ff @(posedge MCLK) begin
    if (RESET) div_cnt <= DIV_RESET;
    else       div_cnt <= next_div_cnt;
  end

  // ------------------------------------------------------------
  // local uart receiver
  // ------------------------------------------------------------
  logic       rx_busy, next_rx_busy;
  logic [3:0] rx_ovs, next_rx_ovs;
  logic [3:0] rx_cnt, next_rx_cnt;
  logic [7:0] rx_sh, next_rx_sh;
  logic       rx_done, next_rx_done;
  always_comb begin
    next_rx_busy = rx_busy;
    next_rx_ovs  = rx_ovs;
    next_rx_cnt  = rx_cnt;
    next_rx_sh   = rx_sh;
    next_rx_done = 1'b0;
    if (tick) begin
      if (!rx_busy) begin
        if (!UART_RXD) begin
          next_rx_busy = 1'b1;
          next_rx_ovs  = 4'h8;
          next_rx_cnt  = '0;
        end
      end else if (rx_ovs == OVS_LAST) begin
        next_rx_ovs = '0;
        if (rx_cnt == '0 && UART_RXD) begin
          next_rx_busy = 1'b0;  // false start
        end else if (rx_cnt == 4'(CHAR_BITS + 1)) begin
          next_rx_busy = 1'b0;
          next_rx_done = UART_RXD;
        end else begin
          if (rx_cnt != '0) next_rx_sh = {UART_RXD, rx_sh[7:1]};
          next_rx_cnt = rx_cnt + 1'b1;
        end
      end else begin
        next_rx_ovs = rx_ovs + 1'b1;
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      rx_busy <= 1'b0; rx_ovs <= '0; rx_cnt <= '0; rx_sh <= '0; rx_done <= 1'b0;
    end else begin
      rx_busy <= next_rx_busy; rx_ovs <= next_rx_ovs; rx_cnt <= next_rx_cnt;
      rx_sh <= next_rx_sh; rx_done <= next_rx_done;
    end
  end

  // ------------------------------------------------------------
  // transmit fifo and overhead inserter
  // ------------------------------------------------------------
  logic [7:0] txf_data;
  logic       txf_valid, txf_pop;
  svc_byte_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_txf (
    .clk(MCLK), .rst(RESET), .flush(1'b0),
    .in_data(rx_sh), .in_valid(rx_done), .in_ready(),
    .out_data(txf_data), .out_valid(txf_valid), .out_ready(txf_pop));

  logic [3:0] ins_cnt, next_ins_cnt;
  logic [7:0] ins_sh, next_ins_sh;
  logic       ins_bit, next_ins_bit;
  always_comb begin
    next_ins_cnt = ins_cnt;
    next_ins_sh  = ins_sh;
    next_ins_bit = ins_bit;
    txf_pop      = 1'b0;
    if (TX_SLOT) begin
      // bits go out one per slot strobe, so spacing follows the framer
      if (ins_cnt == '0) begin
        if (txf_valid) begin
          txf_pop      = 1'b1;
          next_ins_sh  = txf_data;
          next_ins_bit = MARKER_BIT;
          next_ins_cnt = 4'h1;
        end else begin
          next_ins_bit = IDLE_BIT;
        end
      end else begin
        next_ins_bit = ins_sh[0];
        next_ins_sh  = {1'b0, ins_sh[7:1]};
        next_ins_cnt = (ins_cnt == BIT_CNT_LAST) ? 4'h0 : ins_cnt + 1'b1;
      end
    end
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ins_cnt <= '0; ins_sh <= '0; ins_bit <= IDLE_BIT;
    end else begin
      ins_cnt <= next_ins_cnt; ins_sh <= next_ins_sh; ins_bit <= next_ins_bit;
    end
  end
  assign TX_BIT = ins_bit;

  // ------------------------------------------------------------
  // overhead extractor and receive fifo
  // ------------------------------------------------------------
  logic [3:0] ext_cnt, next_ext_cnt;
  logic [7:0] ext_sh, next_ext_sh;
  logic       ext_push, next_ext_push;
  logic       rxf_ready, rxf_valid, rxf_pop, overrun;
  logic [7:0] rxf_data;
  logic       ovr, next_ovr;
  assign overrun = ext_push && !rxf_ready;
  always_comb begin
    next_ext_cnt  = ext_cnt;
    next_ext_sh   = ext_sh;
    next_ext_push = 1'b0;
    if (overrun) begin
      next_ext_cnt = '0;
    end else if (RX_SLOT) begin
      // every assigned bit is decoded, whatever the far end put there, except one whose slot falls in an overrun cycle
      if (ext_cnt == '0) begin
        if (RX_BIT == MARKER_BIT) next_ext_cnt = 4'h1;
      end else begin
        next_ext_sh  = {RX_BIT, ext_sh[7:1]};
        next_ext_cnt = (ext_cnt == BIT_CNT_LAST) ? 4'h0 : ext_cnt + 1'b1;
        next_ext_push = (ext_cnt == BIT_CNT_LAST);
      end
    end
    next_ovr = overrun ? 1'b1 : (OVR_CLR ? 1'b0 : ovr);
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      ext_cnt <= '0; ext_sh <= '0; ext_push <= 1'b0; ovr <= 1'b0;
    end else begin
      ext_cnt <= next_ext_cnt; ext_sh <= next_ext_sh;
      ext_push <= next_ext_push; ovr <= next_ovr;
    end
  end
  assign OVR_FLAG = ovr;

  // flush on overrun so no stale character lingers behind newer ones
  svc_byte_fifo #(.DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_rxf (
    .clk(MCLK), .rst(RESET), .flush(overrun),
    .in_data(ext_sh), .in_valid(ext_push), .in_ready(rxf_ready),
    .out_data(rxf_data), .out_valid(rxf_valid), .out_ready(rxf_pop));

  // ------------------------------------------------------------
  // output uart
  // ------------------------------------------------------------
  uart_tx_state_t tx_st, next_tx_st;
  logic [3:0] tx_ovs, next_tx_ovs;
  logic [2:0] tx_cnt, next_tx_cnt;
  logic [7:0] tx_sh, next_tx_sh;
  logic       txd, next_txd;
  always_comb begin
    next_tx_st  = tx_st;
    next_tx_ovs = tx_ovs;
    next_tx_cnt = tx_cnt;
    next_tx_sh  = tx_sh;
    next_txd    = txd;
    rxf_pop     = 1'b0;
    case (tx_st)
      TX_IDLE: begin
        next_txd = 1'b1;
        if (rxf_valid && tick && !overrun) begin
          rxf_pop     = 1'b1;
          next_tx_sh  = rxf_data;
          next_tx_st  = TX_START;
          next_tx_ovs = '0;
          next_txd    = 1'b0;
        end
      end
      default: begin
        if (tick) begin
          next_tx_ovs = tx_ovs + 1'b1;
          if (tx_ovs == OVS_LAST) begin
            case (tx_st)
              TX_START: begin
                next_tx_st = TX_DATA; next_txd = tx_sh[0]; next_tx_cnt = '0;
              end
              TX_DATA: begin
                if (tx_cnt == 3'h7) begin
                  next_tx_st = TX_STOP; next_txd = 1'b1;
                end else begin
                  next_tx_cnt = tx_cnt + 1'b1;
                  next_txd = tx_sh[next_tx_cnt];
                end
              end
              default: next_tx_st = TX_IDLE;
            endcase
          end
        end
      end
    endcase
  end
  always_ff @(posedge MCLK) begin
    if (RESET) begin
      tx_st <= TX_IDLE; tx_ovs <= '0; tx_cnt <= '0; tx_sh <= '0; txd <= 1'b1;
    end else begin
      tx_st <= next_tx_st; tx_ovs <= next_tx_ovs; tx_cnt <= next_tx_cnt;
      tx_sh <= next_tx_sh; txd <= next_txd;
    end
  end
  assign UART_TXD = txd;

  // ------------------------------------------------------------
  // checks
  // ------------------------------------------------------------
  marker_first_a: assert property (@(posedge MCLK) disable iff (RESET)
    TX_SLOT && ins_cnt == '0 && txf_valid |=> TX_BIT == MARKER_BIT)
    else $error("marker not sent before character");
  idle_high_a: assert property (@(posedge MCLK) disable iff (RESET)
    TX_SLOT && ins_cnt == '0 && !txf_valid |=> TX_BIT == IDLE_BIT)
    else $error("idle channel sent a marker");
  slot_hold_a: assert property (@(posedge MCLK) disable iff (RESET)
    !TX_SLOT |=> $stable(TX_BIT))
    else $error("overhead bit changed without a slot");
  ovr_sticky_a: assert property (@(posedge MCLK) disable iff (RESET)
    overrun |=> OVR_FLAG && !rxf_valid && ext_cnt == '0)
    else $error("overrun not flagged or flushed");
  ovr_hold_a: assert property (@(posedge MCLK) disable iff (RESET)
    OVR_FLAG && !OVR_CLR |=> OVR_FLAG)
    else $error("overrun flag dropped");
  n_range_a: assert property (@(posedge MCLK) disable iff (RESET)
    OH_DIVISOR >= 9'h001 && OH_DIVISOR <= N_RESET)
    else $error("divisor out of range");
  all_remain_a: assert property (@(posedge MCLK) disable iff (RESET)
    ALL_REMAIN |=> OH_DIVISOR == 9'h001)
    else $error("all remaining not full share");
  bit_count_a: assert property (@(posedge MCLK) disable iff (RESET)
    ext_push |-> $past(ext_cnt) == BIT_CNT_LAST)
    else $error("byte pushed at wrong bit");
  drain_tick_a: assert property (@(posedge MCLK) disable iff (RESET)
    rxf_pop |-> tick && tx_st == TX_IDLE)
    else $error("fifo drained off baud");
  stop_high_a: assert property (@(posedge MCLK) disable iff (RESET)
    tx_st == TX_STOP |-> UART_TXD == 1'b1)
    else $error("output stop bit not high");
  cov_char_c: cover property (@(posedge MCLK) ext_push);
  cov_ovr_c:  cover property (@(posedge MCLK) overrun);
  cov_tx_c:   cover property (@(posedge MCLK) txf_pop);

endmodule : svc_async_mux

// *** dv/svc_far_framer.sv ***
// far-end overhead framer model: makes slot strobes, decodes tx bits, sends rx bytes
// assumes the bench drives on the same 2 ns offset after the rising edge
`timescale 1ns/1ps
module svc_far_framer (
  input  wire logic clk,     // frame clock
  input  wire logic rst,     // sync reset
  output logic      tx_slot, // tx overhead strobe
  input  wire logic tx_bit,  // bit for the slot
  output logic      rx_slot, // rx overhead strobe
  output logic      rx_bit   // rx overhead bit
);
  int         tx_gap = 0;
  int         rx_gap = 0;
  bit         tx_en  = 1'b0;
  int         tc;
  int         rc;
  int         nb;
  logic       pend;
  logic [7:0] sh;
  logic [7:0] got[$];
  logic       bits[$];

  // ------------------------------------------------------------
  // strobes; tx slots may be stalled, gap 0 means consecutive bits
  // ------------------------------------------------------------
  initial begin
    {tx_slot, rx_slot, rx_bit, pend} = 4'h0;
    tc = 0;
    rc = 0;
    forever begin
      @(posedge clk);
      #2;
      tx_slot = tx_en && (tc == 0);
      tc = (tc >= tx_gap) ? 0 : tc + 1;
      rx_slot = (rc == 0) && !rst;
      rc = (rc >= rx_gap) ? 0 : rc + 1;
      // idle slots carry 1; outside a slot the line wanders
      if (rx_slot) rx_bit = (bits.size() > 0) ? bits.pop_front() : 1'b1;
      else rx_bit = ~rx_bit;
    end
  end

  task automatic send_byte(input logic [7:0] b);
    bits.push_back(1'b0);
    for (int i = 0; i < 8; i++) bits.push_back(b[i]);
  endtask : send_byte

  // ------------------------------------------------------------
  // tx decoder: bit is read one edge after its slot was taken
  // ------------------------------------------------------------
  always @(posedge clk) begin
    if (rst) nb = 0;
    else if (pend && nb == 0) nb = (tx_bit === 1'b0) ? 1 : 0;
    else if (pend) begin
      sh = {tx_bit, sh[7:1]};
      nb = (nb == 8) ? 0 : nb + 1;
      if (nb == 0) got.push_back(sh);
    end
    pend = tx_slot && !rst;
  end
endmodule : svc_far_framer

// *** dv/async_overhead_channel_mux_test.sv ***
// self-checking bench for the service async channel framer
// assumes svc_far_framer as the far end and a 40 MHz clock
`timescale 1ns/1ps
module async_overhead_channel_mux_test;
  import svc_chan_pkg::*;
  localparam int    BIT_CLKS = 32; // 16 ticks of 2 clocks at BAUD_DIV 1
  logic             MCLK, RESET, MIN_OH, ALL_REMAIN, UART_RXD, UART_TXD;
  logic             TX_SLOT, TX_BIT, RX_SLOT, RX_BIT, OVR_CLR, OVR_FLAG;
  logic [DIV_W-1:0] BAUD_DIV;
  logic [31:0]      OH_BITS_RATE, REQ_BITS_RATE;
  logic [N_W-1:0]   OH_DIVISOR;
  int               failures, n_compared, cyc;
  logic [7:0]       exp_q[$], cq[$], rx_got[$];

  svc_async_mux uut (.MCLK(MCLK), .RESET(RESET), .BAUD_DIV(BAUD_DIV),
    .OH_BITS_RATE(OH_BITS_RATE), .REQ_BITS_RATE(REQ_BITS_RATE), .MIN_OH(MIN_OH),
    .ALL_REMAIN(ALL_REMAIN), .OH_DIVISOR(OH_DIVISOR), .UART_RXD(UART_RXD),
    .UART_TXD(UART_TXD), .TX_SLOT(TX_SLOT), .TX_BIT(TX_BIT), .RX_SLOT(RX_SLOT),
    .RX_BIT(RX_BIT), .OVR_CLR(OVR_CLR), .OVR_FLAG(OVR_FLAG));
  svc_far_framer far (.clk(MCLK), .rst(RESET), .tx_slot(TX_SLOT), .tx_bit(TX_BIT),
    .rx_slot(RX_SLOT), .rx_bit(RX_BIT));

  initial begin
    MCLK = 1'b0;
    forever #12.5 MCLK = ~MCLK;
  end

  // ------------------------------------------------------------
  // checks and verdict
  // ------------------------------------------------------------
  task automatic tally(input logic [8:0] got, input logic [8:0] exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : tally
  task automatic chk_n(input logic [N_W-1:0] g, input logic [N_W-1:0] e);
    tally(g, e);
  endtask : chk_n
  task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
    tally({1'b0, g}, {1'b0, e});
  endtask : chk_byte
  task automatic chk_bit(input logic g, input logic e);
    tally({8'h00, g}, {8'h00, e});
  endtask : chk_bit
  task automatic cmp_q();
    chk_n(N_W'(cq.size()), N_W'(exp_q.size()));
    while (cq.size() > 0 && exp_q.size() > 0) chk_byte(cq.pop_front(), exp_q.pop_front());
    cq.delete();
    exp_q.delete();
  endtask : cmp_q
  task automatic end_sim();
    $display("compared %0d failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_sim

  // run needs about 15k cycles; ceiling leaves margin
  always @(posedge MCLK) begin
    cyc++;
    if (cyc == 30000) begin
      failures++;
      end_sim();
    end
  end

  task automatic step(input int n);
    repeat (n) @(posedge MCLK);
    #2;
  endtask : step
  task automatic uart_send(input logic [7:0] b);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++) begin
      UART_RXD = f[i];
      step(BIT_CLKS);
    end
  endtask : uart_send

  // local uart receiver, samples mid-bit
  initial begin
    logic [7:0] b;
    forever begin
      @(negedge UART_TXD);
      if (RESET !== 1'b0) continue;
      repeat (BIT_CLKS / 2) @(posedge MCLK);
      for (int i = 0; i < 8; i++) begin
        repeat (BIT_CLKS) @(posedge MCLK);
        b[i] = UART_TXD;
      end
      repeat (BIT_CLKS) @(posedge MCLK);
      chk_bit(UART_TXD, 1'b1);
      rx_got.push_back(b);
    end
  end

  // ------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------
  initial begin
    logic [7:0]  b;
    logic [31:0] oh, req;
    int          en;
    {RESET, MIN_OH, ALL_REMAIN, OVR_CLR, UART_RXD} = 5'h11;
    BAUD_DIV = 16'h0001;
    OH_BITS_RATE = 32'h0000_0100;
    REQ_BITS_RATE = 32'h0000_0001;
    void'($urandom(33));
    step(5);
    chk_n(OH_DIVISOR, 9'h100);
    chk_bit(UART_TXD, 1'b1);
    chk_bit(TX_BIT, IDLE_BIT);
    chk_bit(OVR_FLAG, 1'b0);
    RESET = 1'b0;
    $display("test reset done");
    for (int i = 0; i < 40; i++) begin
      req = $urandom_range(1, 4000);
      oh = req * $urandom_range(1, 300) + $urandom_range(0, req - 1);
      if (i == 2) oh = req * 256;
      if (i == 3) oh = req * 256 - 1;
      MIN_OH = (i != 0);
      ALL_REMAIN = (i % 8 == 5);
      OH_BITS_RATE = oh;
      REQ_BITS_RATE = req;
      en = 1;
      if (MIN_OH && !ALL_REMAIN) for (int n = 1; n <= 256; n++) if (oh >= req * n) en = n;
      step(3);
      chk_n(OH_DIVISOR, N_W'(en));
    end
    $display("test divisor done");
    far.tx_en = 1'b1;
    // first baud tick only comes after the reset count runs out
    step(int'(DIV_RESET) + 300);
    chk_n(N_W'(far.got.size()), 9'h000);
    for (int i = 0; i < 5; i++) begin
      if (i == 3) far.tx_gap = 7;
      b = 8'($urandom);
      exp_q.push_back(b);
      uart_send(b);
    end
    step(400);
    cq = far.got;
    far.got.delete();
    cmp_q();
    $display("test tx done");
    // far end stalls while the tx fifo fills past its depth
    far.tx_en = 1'b0;
    for (int i = 0; i < 6; i++) begin
      b = 8'($urandom);
      if (i < FIFO_DEPTH) exp_q.push_back(b);
      uart_send(b);
    end
    far.tx_en = 1'b1;
    step(400);
    cq = far.got;
    far.got.delete();
    cmp_q();
    $display("test tx fifo done");
    far.rx_gap = 39;
    for (int i = 0; i < 3; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      far.send_byte(b);
    end
    step(2000);
    cq = rx_got;
    rx_got.delete();
    cmp_q();
    $display("test rx done");
    far.rx_gap = 0;
    for (int i = 0; i < 12; i++) far.send_byte(8'($urandom));
    step(120);
    chk_bit(OVR_FLAG, 1'b1);
    step(400);
    chk_bit(OVR_FLAG, 1'b1);
    OVR_CLR = 1'b1;
    step(1);
    OVR_CLR = 1'b0;
    step(1);
    chk_bit(OVR_FLAG, 1'b0);
    // garbage from the burst drains out before the recovery check
    step(2000);
    rx_got.delete();
    far.rx_gap = 39;
    for (int i = 0; i < 2; i++) begin
      b = 8'($urandom);
      exp_q.push_back(b);
      far.send_byte(b);
    end
    step(1500);
    cq = rx_got;
    rx_got.delete();
    cmp_q();
    chk_bit(OVR_FLAG, 1'b0);
    $display("test overrun done");
    end_sim();
  end
endmodule : async_overhead_channel_mux_test
